/* File: hdl/tcs_defines.svh */
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// register byte offsets
`define TCS_GCR 8'h00
`define TCS_PINDIS 8'h04
`define TCS_MON 8'h08
`define TCS_STAT 8'h0C
`define TCS_MASK 8'h10
`define TCS_CNT 8'h14
`define TCS_RADDR 8'h18
`define TCS_RPRG 8'h1C
`define TCS_RCTL 8'h20
`define TCS_RDAT 8'h24
`define TCS_TUCFG 8'h28
`define TCS_TUEN 8'h2C
`define TCS_FLT0 8'h30
`define TCS_MCMP 8'h40

// field positions
`define TCS_GCR_MASTER 16
`define TCS_GCR_LOOP_HI 5
`define TCS_MON_INTONLY 0
`define TCS_ST_ALIGN 0
`define TCS_ST_LOST 1
`define TCS_ST_PAR 2
`define TCS_ST_PDIS 3
`define TCS_ST_MON 4

// reset values
`define TCS_GCR_RST 32'h0000_001F
`define TCS_FLT_RST 32'h0000_0000

// sizes and timing
`define TCS_RAM_WORDS 160
`define TCS_RAM_BANKS 4
`define TCS_RAM_ROWS 40
`define TCS_FIELD_W 32
`define TCS_SYNC_LAT 7'h03

`endif

/* File: hdl/tcs_pkg.sv */
`default_nettype none

package tcs_pkg;

    typedef enum logic [1:0] {TU_ONESHOT, TU_CIRCULAR, TU_SWITCH} tcs_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tcs_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } tcs_apb_rsp_t;

    typedef struct packed {
        logic [31:0] val;
        logic [31:0] oe;
    } tcs_pins_t;

    typedef struct packed {
        logic [31:0] prg;
        logic [31:0] ctl;
        logic [31:0] dat;
    } tcs_word_t;

    typedef struct packed {
        tcs_apb_rsp_t apb;
        logic [31:0] gcr;
        logic [31:0] pindis;
        logic [31:0] mon;
        logic [31:0] mcmp;
        logic [4:0] stat;
        logic [4:0] mask;
        logic irq;
        logic [2:0] sync_s;
        logic [2:0] dis_s;
        logic [31:0] in1;
        logic [31:0] in2;
        logic [31:0] filt;
        logic [31:0][3:0] fcnt;
        logic [3:0][31:0] flt;
        logic [31:0] pm1;
        logic [31:0] pm2;
        logic [6:0] lr;
        logic [24:0] virt;
        logic aligned;
        logic sync_out;
        tcs_pins_t pins;
        logic tap;
        logic [7:0] pend;
        logic [7:0] tuen;
        logic [7:0] tubuf;
        logic [5:0] tucfg;
        logic [7:0] raddr;
        logic [63:0] stage;
        tcs_word_t rd;
        logic [2:0] rdpar;
        logic rdv;
        logic [159:0] wv;
    } tcs_state_t;

endpackage : tcs_pkg

`default_nettype wire

/* File: hdl/tcs_top.sv */
// The implementer's own choices: the address map and register access over APB.
`include "tcs_defines.svh"
`default_nettype none

module tcs_top #(
    parameter int TAP_CH = 31
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_CE,
    // register bus
    input wire tcs_pkg::tcs_apb_req_t I_APB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // timer pins
    input wire logic [31:0] I_PIN_IN,
    input wire logic [31:0] I_PIN_VAL,
    input wire logic [31:0] I_PIN_DRV,
    output tcs_pkg::tcs_pins_t O_PINS,
    output logic [31:0] O_PIN_FILT,
    input wire logic I_PIN_DIS_N,
    // synchronisation
    input wire logic I_SYNC_IN,
    output logic O_SYNC_OUT,
    output logic [31:0] O_COUNT,
    // monitoring
    output logic O_CMP_TAP,
    input wire logic [31:0] I_PEER_PIN,
    input wire logic I_MON_EN,
    // transfer unit
    input wire logic [7:0] I_XFER_REQ,
    input wire logic [7:0] I_XFER_DONE,
    output logic [7:0] O_XFER_PEND,
    output logic [5:0] O_TU_CFG,
    // interrupt
    output logic O_IRQ
);
    import tcs_pkg::*;

    tcs_state_t s;
    tcs_state_t d;
    logic [98:0] ram [`TCS_RAM_BANKS][`TCS_RAM_ROWS];
    logic acc;
    logic done;
    logic wr;
    logic rd_stat;
    logic hit;
    logic [31:0] rdat;
    logic [4:0] ev;
    logic wr_mem;
    logic [98:0] wdata;
    logic rvalid;
    logic [98:0] rword;
    logic [6:0] top;
    logic wrap;
    logic rise;
    tcs_mode_t mode;

    assign top = {1'b0, s.gcr[`TCS_GCR_LOOP_HI:0]};
    assign wrap = (s.lr == top);
    assign rise = s.sync_s[1] & ~s.sync_s[2];
    assign acc = I_APB.psel & I_APB.penable;
    assign done = acc & s.apb.pready;
    assign wr = done & I_APB.pwrite;
    assign rvalid = (s.raddr < 8'(`TCS_RAM_WORDS));
    // bank from low bits so neighbouring words sit in different banks
    assign rword = ram[s.raddr[1:0]][s.raddr[7:2]];
    // parity bits sit in field order: program, control, data
    assign wdata = {^s.stage[63:32], ^s.stage[31:0], ^I_APB.pwdata,
        s.stage[63:32], s.stage[31:0], I_APB.pwdata};
    assign mode = tcs_mode_t'(s.tucfg[1:0]);

    always_comb begin
        hit = 1'b1;
        rdat = 32'h0000_0000;
        unique case (I_APB.paddr)
            `TCS_GCR: rdat = s.gcr;
            `TCS_PINDIS: rdat = s.pindis;
            `TCS_MON: rdat = s.mon;
            `TCS_STAT: rdat = {27'h0000000, s.stat};
            `TCS_MASK: rdat = {27'h0000000, s.mask};
            `TCS_CNT: rdat = {s.virt, s.lr};
            `TCS_RADDR: rdat = {24'h000000, s.raddr};
            `TCS_RPRG: rdat = s.rd.prg;
            `TCS_RCTL: rdat = s.rd.ctl;
            `TCS_RDAT: rdat = s.rd.dat;
            `TCS_TUCFG: rdat = {26'h0000000, s.tucfg};
            `TCS_TUEN: rdat = {16'h0000, s.tubuf, s.tuen};
            `TCS_FLT0: rdat = s.flt[0];
            8'h34: rdat = s.flt[1];
            8'h38: rdat = s.flt[2];
            8'h3C: rdat = s.flt[3];
            `TCS_MCMP: rdat = s.mcmp;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        d = s;
        ev = 5'h00;
        rd_stat = 1'b0;
        wr_mem = 1'b0;
        if (I_CE) begin
            // bus slave: one wait state, then a one-cycle ready
            d.apb.pready = acc & ~s.apb.pready;
            d.apb.pslverr = acc & ~s.apb.pready & ~hit;
            d.apb.prdata = (acc & ~I_APB.pwrite) ? rdat : 32'h0000_0000;
            rd_stat = done & ~I_APB.pwrite & hit
                & (I_APB.paddr == `TCS_STAT);
            if (wr & hit) begin
                unique case (I_APB.paddr)
                    `TCS_GCR: d.gcr = I_APB.pwdata;
                    `TCS_PINDIS: d.pindis = I_APB.pwdata;
                    `TCS_MON: d.mon = I_APB.pwdata;
                    `TCS_MASK: d.mask = I_APB.pwdata[4:0];
                    `TCS_RADDR: d.raddr = I_APB.pwdata[7:0];
                    `TCS_RPRG: d.stage[63:32] = I_APB.pwdata;
                    `TCS_RCTL: d.stage[31:0] = I_APB.pwdata;
                    `TCS_RDAT: wr_mem = rvalid;
                    `TCS_TUCFG: d.tucfg = I_APB.pwdata[5:0];
                    `TCS_TUEN: d.tuen = I_APB.pwdata[7:0];
                    `TCS_FLT0: d.flt[0] = I_APB.pwdata;
                    8'h34: d.flt[1] = I_APB.pwdata;
                    8'h38: d.flt[2] = I_APB.pwdata;
                    8'h3C: d.flt[3] = I_APB.pwdata;
                    `TCS_MCMP: d.mcmp = I_APB.pwdata;
                    default: ;
                endcase
            end
            if (wr_mem) begin
                d.wv[s.raddr] = 1'b1;
            end

            // read port runs every cycle beside the write port
            d.rd = rword[95:0];
            d.rdpar = rword[98:96];
            d.rdv = rvalid & s.wv[s.raddr];
            ev[`TCS_ST_PAR] = s.rdv & ((^s.rd.prg != s.rdpar[2])
                | (^s.rd.ctl != s.rdpar[1])
                | (^s.rd.dat != s.rdpar[0]));

            // input synchronisers and suppression filters
            d.in1 = I_PIN_IN;
            d.in2 = s.in1;
            for (int i = 0; i < 32; i++) begin
                if (s.in2[i] == s.filt[i]) begin
                    d.fcnt[i] = 4'h0;
                end else if (s.fcnt[i] >= s.flt[i / 8][(i % 8) * 4 +: 4]) begin
                    d.filt[i] = s.in2[i];
                    d.fcnt[i] = 4'h0;
                end else begin
                    d.fcnt[i] = s.fcnt[i] + 4'h1;
                end
            end

            // loop prescaler with 25-bit virtual extension
            d.sync_s = {s.sync_s[1:0], I_SYNC_IN};
            if (wrap) begin
                d.lr = 7'h00;
                d.virt = s.virt + 25'h0000001;
            end else begin
                d.lr = s.lr + 7'h01;
            end
            d.sync_out = s.gcr[`TCS_GCR_MASTER] & wrap;
            // latency covers the pulse flop and two sync stages
            if (~s.gcr[`TCS_GCR_MASTER] & rise) begin
                d.lr = `TCS_SYNC_LAT;
                d.aligned = 1'b1;
                ev[`TCS_ST_ALIGN] = 1'b1;
            end

            // pin drive with fault disable and internal-only tap
            // third stage only for the edge, first flop read by none
            d.dis_s = {s.dis_s[1:0], I_PIN_DIS_N};
            ev[`TCS_ST_PDIS] = s.dis_s[2] & ~s.dis_s[1];
            d.pins.val = I_PIN_VAL;
            d.pins.oe = I_PIN_DRV & ~(s.dis_s[1] ? 32'h0000_0000
                : s.pindis);
            if (s.mon[`TCS_MON_INTONLY]) begin
                d.pins.oe[TAP_CH] = 1'b0;
            end
            d.tap = I_PIN_VAL[TAP_CH];

            // peer monitoring only when the mux routes it here
            d.pm1 = I_PEER_PIN;
            d.pm2 = s.pm1;
            ev[`TCS_ST_MON] = I_MON_EN
                & (|((s.pm2 ^ s.pins.val) & s.mcmp));

            // transfer unit request tracking per packet
            d.pend = (s.pend & ~I_XFER_DONE)
                | (I_XFER_REQ & s.tuen);
            ev[`TCS_ST_LOST] = |(I_XFER_REQ & s.tuen & s.pend
                & ~I_XFER_DONE);
            unique case (mode)
                TU_ONESHOT: d.tuen = d.tuen & ~I_XFER_DONE;
                TU_CIRCULAR: ;
                TU_SWITCH: d.tubuf = s.tubuf ^ I_XFER_DONE;
                default: ;
            endcase

            // read clears, a same-cycle event still sets
            d.stat = (rd_stat ? 5'h00 : s.stat) | ev;
            d.irq = |(d.stat & s.mask);
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            s <= '0;
            s.gcr <= `TCS_GCR_RST;
            s.flt <= {4{`TCS_FLT_RST}};
            s.sync_s <= 3'h0;
            s.dis_s <= 3'h7;
        end else begin
            s <= d;
        end
    end

    // memory has no reset; unwritten words are tracked by wv
    always_ff @(posedge I_CLK) begin
        if (I_CE && wr_mem) begin
            ram[s.raddr[1:0]][s.raddr[7:2]] <= wdata;
        end
    end

    assign O_PRDATA = s.apb.prdata;
    assign O_PREADY = s.apb.pready;
    assign O_PSLVERR = s.apb.pslverr;
    assign O_PINS = s.pins;
    assign O_PIN_FILT = s.filt;
    assign O_SYNC_OUT = s.sync_out;
    assign O_COUNT = {s.virt, s.lr};
    assign O_CMP_TAP = s.tap;
    assign O_XFER_PEND = s.pend;
    assign O_TU_CFG = s.tucfg;
    assign O_IRQ = s.irq;

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    slave_quiet_a: assert property (
        I_CE && !s.gcr[`TCS_GCR_MASTER] |=> !O_SYNC_OUT)
        else $error("slave drove a sync pulse");
    master_pulse_a: assert property (
        I_CE && s.gcr[`TCS_GCR_MASTER] && wrap |=> O_SYNC_OUT ##1 !O_SYNC_OUT
        || !I_CE)
        else $error("master sync pulse missing");
    slave_align_a: assert property (
        I_CE && !s.gcr[`TCS_GCR_MASTER] && rise
        |=> s.lr == `TCS_SYNC_LAT && s.aligned && s.stat[`TCS_ST_ALIGN])
        else $error("slave did not realign");
    free_run_a: assert property (
        I_CE && s.aligned && !rise && !wrap
        |=> s.lr == $past(s.lr) + 7'h01)
        else $error("aligned prescaler lost phase");
    virt_step_a: assert property (
        I_CE && wrap |=> s.virt == $past(s.virt) + 25'h0000001
        && s.lr == 7'h00 || $past(rise))
        else $error("virtual counter did not step");
    pin_off_a: assert property (
        I_CE && !s.dis_s[1]
        |=> (O_PINS.oe & $past(s.pindis)) == 32'h0000_0000)
        else $error("disabled pin still driven");
    tap_follow_a: assert property (
        I_CE |=> O_CMP_TAP == $past(I_PIN_VAL[TAP_CH]))
        else $error("comparator tap wrong");
    req_pend_a: assert property (
        I_CE |=> (O_XFER_PEND & $past(I_XFER_REQ & s.tuen))
        == $past(I_XFER_REQ & s.tuen))
        else $error("request not pending on its packet");
    lost_flag_a: assert property (
        I_CE && |(I_XFER_REQ & s.tuen & s.pend & ~I_XFER_DONE)
        |=> s.stat[`TCS_ST_LOST] ##1 (s.stat[`TCS_ST_LOST] || !I_CE
        || $past(rd_stat)))
        else $error("lost request not flagged");
    ready_once_a: assert property (
        O_PREADY |=> !O_PREADY || !$past(I_CE))
        else $error("ready held two cycles");

endmodule : tcs_top

`default_nettype wire

/* File: dv/tcs_pin_model.sv */
`default_nettype none

module tcs_pin_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // pad side
    input wire tcs_pkg::tcs_pins_t i_pins,
    output logic [31:0] o_pin_in,
    output logic [31:0] o_peer_pin,
    output logic o_settled
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;

    integer seed = 32'h1414;
    logic [4:0] age_q;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            age_q <= 5'h00;
            o_pin_in <= 32'h0000_0000;
            o_peer_pin <= 32'h0000_0000;
        end else begin
            age_q <= age_q + 5'h01;
            // sensors move every 32 cycles, far inside the capture range
            if (age_q == 5'h1F) begin
                o_pin_in <= $random(seed);
            end
            // peer timer mirrors our pads one cycle late, so monitoring sees agreement only while the pads hold
            o_peer_pin <= i_pins.val;
        end
    end

    // sync and filter delay are well under a dozen cycles
    assign o_settled = (age_q > 5'h0C);
endmodule : tcs_pin_model

`default_nettype wire

/* File: dv/timer_coprocessor_sync_and_transfer_bench.sv */
`include "tcs_defines.svh"
`default_nettype none

module timer_coprocessor_sync_and_transfer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import tcs_pkg::*;

    logic clk, reset_n, ce, pready, pslverr, pin_dis_n, sync_in, sync_out;
    logic cmp_tap, mon_en, irq, settled, err_v;
    tcs_apb_req_t bus_req;
    tcs_pins_t pins;
    logic [31:0] prdata, pin_in, pin_val, pin_drv, pin_filt, count, peer_pin;
    logic [31:0] rd_v, mask, w0, w1, w2;
    logic [7:0] xreq, xdone, xpend;
    logic [5:0] tu_cfg;
    integer seed, mismatches, tests_run, n, k, c;

    tcs_top u_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_CE(ce),
        .I_APB(bus_req), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .I_PIN_IN(pin_in), .I_PIN_VAL(pin_val),
        .I_PIN_DRV(pin_drv), .O_PINS(pins), .O_PIN_FILT(pin_filt),
        .I_PIN_DIS_N(pin_dis_n), .I_SYNC_IN(sync_in), .O_SYNC_OUT(sync_out),
        .O_COUNT(count), .O_CMP_TAP(cmp_tap), .I_PEER_PIN(peer_pin),
        .I_MON_EN(mon_en), .I_XFER_REQ(xreq), .I_XFER_DONE(xdone),
        .O_XFER_PEND(xpend), .O_TU_CFG(tu_cfg), .O_IRQ(irq));

    tcs_pin_model u_pins (.i_clk(clk), .i_reset_n(reset_n), .i_pins(pins),
        .o_pin_in(pin_in), .o_peer_pin(peer_pin), .o_settled(settled));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic give_up(input integer cnt);
        if (cnt >= 300) begin
            mismatches++;
            $display("CHECK FAILED at %0t: wait ran out", $time);
            end_sim();
        end
    endtask : give_up

    task automatic cyc(input integer cnt);
        repeat (cnt) @(posedge clk);
    endtask : cyc

    // leading edge keeps a release and the next setup apart
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        integer w;
        @(posedge clk);
        w = 0;
        bus_req.psel <= 1'b1;
        bus_req.penable <= 1'b0;
        bus_req.pwrite <= wr;
        bus_req.paddr <= a;
        bus_req.pwdata <= d;
        @(posedge clk);
        bus_req.penable <= 1'b1;
        do begin
            @(posedge clk);
            w++;
        end while (pready !== 1'b1 && w < 300);
        give_up(w);
        rd_v = prdata;
        err_v = pslverr;
        bus_req.psel <= 1'b0;
        bus_req.penable <= 1'b0;
    endtask : bus

    function automatic logic [31:0] tuen_exp(input integer m, input integer b);
        logic [31:0] e;
        e = 32'h0000_00FF;
        if (m == 0) begin
            e[b] = 1'b0;
        end
        if (m == 2) begin
            e[b + 8] = 1'b1;
        end
        return e;
    endfunction : tuen_exp

    initial begin
        seed = 32'h1414;
        mismatches = 0;
        tests_run = 0;
        reset_n = 1'b0;
        ce = 1'b1;
        bus_req = '0;
        pin_val = 32'h0000_0000;
        pin_drv = 32'h0000_0000;
        pin_dis_n = 1'b1;
        sync_in = 1'b0;
        mon_en = 1'b0;
        xreq = 8'h00;
        xdone = 8'h00;
        cyc(2);
        reset_n <= 1'b1;
        bus(1'b0, `TCS_GCR, 32'h0);
        chk(rd_v, `TCS_GCR_RST);
        bus(1'b0, 8'hFC, 32'h0);
        chk({31'h0, err_v}, 32'h1);
        $display("test reset done");

        w0 = $random(seed);
        w1 = $random(seed);
        w2 = $random(seed);
        bus(1'b1, `TCS_RADDR, 32'h5);
        bus(1'b1, `TCS_RPRG, w0);
        bus(1'b1, `TCS_RCTL, w1);
        bus(1'b1, `TCS_RDAT, w2);
        bus(1'b0, `TCS_RPRG, 32'h0);
        chk(rd_v, w0);
        bus(1'b0, `TCS_RCTL, 32'h0);
        chk(rd_v, w1);
        bus(1'b0, `TCS_RDAT, 32'h0);
        chk(rd_v, w2);
        bus(1'b0, `TCS_STAT, 32'h0);
        chk({31'h0, rd_v[`TCS_ST_PAR]}, 32'h0);
        $display("test ram done");

        bus(1'b1, `TCS_GCR, 32'h0001_001F);
        for (n = 0; sync_out !== 1'b1 && n < 300; n++) cyc(1);
        give_up(n);
        cyc(1);
        for (n = 1; sync_out !== 1'b1 && n < 300; n++) cyc(1);
        give_up(n);
        chk(n, 32'd32);
        $display("test master done");

        bus(1'b1, `TCS_GCR, 32'h0000_001F);
        bus(1'b0, `TCS_STAT, 32'h0);
        for (k = 0; k < 2; k++) begin
            sync_in <= 1'b0;
            cyc(3 + ($random(seed) & 15));
            sync_in <= 1'b1;
            cyc(4);
            chk({25'h0, count[6:0]}, 32'h3);
        end
        c = count[6:0];
        cyc(5);
        chk({25'h0, count[6:0]}, (c + 5) % 32);
        bus(1'b0, `TCS_STAT, 32'h0);
        chk({31'h0, rd_v[`TCS_ST_ALIGN]}, 32'h1);
        $display("test slave done");

        mask = $random(seed);
        pin_drv <= 32'hFFFF_FFFF;
        pin_val <= $random(seed);
        bus(1'b1, `TCS_PINDIS, mask);
        bus(1'b1, `TCS_MASK, 32'h8);
        bus(1'b0, `TCS_STAT, 32'h0);
        pin_dis_n <= 1'b0;
        cyc(5);
        chk(pins.oe, ~mask);
        chk({31'h0, irq}, 32'h1);
        bus(1'b0, `TCS_STAT, 32'h0);
        chk({31'h0, rd_v[`TCS_ST_PDIS]}, 32'h1);
        cyc(2);
        chk({31'h0, irq}, 32'h0);
        pin_dis_n <= 1'b1;
        cyc(5);
        chk(pins.oe, 32'hFFFF_FFFF);
        $display("test pin disable done");

        for (c = 0; c < 3; c++) begin
            k = $random(seed) & 7;
            bus(1'b1, `TCS_TUCFG, c);
            bus(1'b1, `TCS_TUEN, 32'hFF);
            bus(1'b0, `TCS_STAT, 32'h0);
            xreq <= 8'h01 << k;
            cyc(1);
            xreq <= 8'h00;
            cyc(2);
            chk({24'h0, xpend}, 32'h1 << k);
            xreq <= 8'h01 << k;
            cyc(1);
            xreq <= 8'h00;
            xdone <= 8'h01 << k;
            cyc(1);
            xdone <= 8'h00;
            cyc(2);
            chk({24'h0, xpend}, 32'h0);
            bus(1'b0, `TCS_STAT, 32'h0);
            chk({31'h0, rd_v[`TCS_ST_LOST]}, 32'h1);
            bus(1'b0, `TCS_TUEN, 32'h0);
            chk(rd_v & 32'hFFFF, tuen_exp(c, k));
        end
        bus(1'b0, `TCS_STAT, 32'h0);
        chk({31'h0, rd_v[`TCS_ST_LOST]}, 32'h0);
        $display("test transfer done");

        mon_en <= 1'b1;
        pin_drv <= 32'hFFFF_FFFF;
        bus(1'b1, `TCS_MON, 32'h1);
        for (k = 0; k < 4; k++) begin
            pin_val <= $random(seed);
            cyc(2);
            chk({31'h0, cmp_tap}, {31'h0, pin_val[31]});
            chk({31'h0, pins.oe[31]}, 32'h0);
        end
        $display("test tap done");

        for (k = 0; k < 3; k++) begin
            cyc(20);
            for (n = 0; settled !== 1'b1 && n < 300; n++) cyc(1);
            give_up(n);
            chk(pin_filt, pin_in);
        end
        $display("test filter done");
        end_sim();
    end
endmodule : timer_coprocessor_sync_and_transfer_bench

`default_nettype wire
